// ---- hdl/adsr_pkg.sv ----
// Shared constants and types for the serial result readout block
package adsr_pkg;

    // ****************************************************************
    // Data layout
    // ****************************************************************
    localparam int   RES_W      = 16;       // Result word width
    localparam int   IDX_W      = 4;        // Bit index width in a frame
    localparam logic SYNC_LEVEL = 1'b1;     // Level of the sync bit
    localparam logic IDLE_LEVEL = 1'b0;     // Serial output when idle

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 10;      // System clock period
    localparam int T_BUSY_MAX_NS = 83;      // Longest start-to-busy delay
    localparam int BUSY_MAX_CYC  =          // Rounded down, at least one
        (T_BUSY_MAX_NS / CLK_PERIOD_NS) < 1 ? 1
        : (T_BUSY_MAX_NS / CLK_PERIOD_NS);
    localparam int T_CONV_NS     = 4000;    // Conversion time, plain default
    localparam int CONV_CYC      =          // Rounded up to whole cycles
        (T_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************************************
    // Link-side frame states, Gray from LS_IDLE through LS_TAIL; LS_TAIL back to LS_ARMED flips both bits
    // ****************************************************************
    typedef enum logic [1:0] {
        LS_IDLE  = 2'h0,
        LS_ARMED = 2'h1,
        LS_SHIFT = 2'h3,
        LS_TAIL  = 2'h2
    } adsr_link_st_t;

endpackage : adsr_pkg

// ---- hdl/adsr_readout.sv ----
// Serial result readout during conversion, with sync bit and tag
module adsr_readout #(
    parameter int W        = adsr_pkg::RES_W,
    parameter int CONV_CYC = adsr_pkg::CONV_CYC
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         serial_shift_clock,
    input  wire logic         cs_n,
    input  wire logic         rc_n,
    input  wire logic         tag_in,
    input  wire logic         clock_source_select,
    input  wire logic [W-1:0] conv_word,
    output logic              busy_n_r,
    output logic              sdata_r
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (W != adsr_pkg::RES_W) begin : g_bad_w
        $error("Word width must match the frame bit index range");
    end
    if (CONV_CYC < 2) begin : g_bad_conv
        $error("Conversion must last at least two cycles");
    end

    localparam int CNT_W = $clog2(CONV_CYC + 1);
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(CONV_CYC - 1);
    localparam logic [adsr_pkg::IDX_W-1:0] IDX_LAST =
        adsr_pkg::IDX_W'(W - 1);
    localparam int BUSY_BOUND = adsr_pkg::BUSY_MAX_CYC;

    // ****************************************************************
    // System clock side: conversion timing and result hand-off
    // ****************************************************************
    logic             rc_s1_r, rc_s2_r, rc_s3_r;  // Convert select sync
    logic             cs_s1_r, cs_s2_r;           // Chip select sync
    logic [CNT_W-1:0] cnt_r, cnt_nxt;             // Conversion countdown
    logic             busy_nxt;                   // Next busy level
    logic             wr_en;                      // Store new result
    logic             wr_dly_r;                   // Store has updated
    logic             xfer_tgl_r, xfer_tgl_nxt;   // Word-ready toggle
    logic [W-1:0]     res_word;                   // Last finished result
    logic             conv_start;                 // Conversion request

    // Synchronisers for the control pins: three flops for convert select, two for chip select
    always_ff @(posedge clk) begin
        rc_s1_r <= rc_n;
        rc_s2_r <= rc_s1_r;
        rc_s3_r <= rc_s2_r;
        cs_s1_r <= cs_n;
        cs_s2_r <= cs_s1_r;
    end

    // Convert select fell while selected and not already converting
    assign conv_start = rc_s3_r & ~rc_s2_r & ~cs_s2_r & busy_n_r;

    // Next state of the conversion sequencer
    always_comb begin
        busy_nxt     = busy_n_r;
        cnt_nxt      = cnt_r;
        wr_en        = 1'b0;
        xfer_tgl_nxt = xfer_tgl_r ^ wr_dly_r;
        if (conv_start) begin
            // Busy goes low within a few cycles of the pin falling
            busy_nxt = 1'b0;
            cnt_nxt  = CNT_LOAD;
        end else if (!busy_n_r) begin
            if (cnt_r == '0) begin
                // End of conversion: store result, release busy
                busy_nxt = 1'b1;
                wr_en    = 1'b1;
            end else begin
                cnt_nxt = cnt_r - CNT_W'(1);
            end
        end
    end

    // Registers of the conversion sequencer
    always_ff @(posedge clk) begin
        if (srst) begin
            busy_n_r   <= 1'b1;
            cnt_r      <= '0;
            wr_dly_r   <= 1'b0;
            xfer_tgl_r <= 1'b0;
        end else begin
            busy_n_r   <= busy_nxt;
            cnt_r      <= cnt_nxt;
            wr_dly_r   <= wr_en;
            xfer_tgl_r <= xfer_tgl_nxt;
        end
    end

    // Result changes only at a conversion end, so while conversion n
    // runs the store still holds n-1
    adsr_result_store #(
        .W       (W)
    ) u_store (
        .clk     (clk),
        .srst    (srst),
        .wr_en   (wr_en),
        .wr_data (conv_word),
        .rd_data (res_word)
    );

    // ****************************************************************
    // Link side: frame sequencer on the serial shift clock
    // ****************************************************************
    logic                        lrst_s1_r, lrst_r;  // Reset synchroniser
    logic                        ext_s1_r, ext_r;    // Clock source sync
    logic                        tg_s1_r, tg_s2_r, tg_s3_r; // Toggle sync
    logic [W-1:0]                shadow_r, shadow_nxt;      // Word to send
    adsr_pkg::adsr_link_st_t     st_r, st_nxt;       // Frame state
    logic [adsr_pkg::IDX_W-1:0]  idx_r, idx_nxt;     // Bit index
    logic                        tag_r, tag_nxt;     // Captured tag
    logic                        sdata_nxt;          // Next serial bit
    logic                        arm_cond;           // Sync may be armed
    logic                        go_cond;            // Sync requested

    // Synchronisers into the link domain; the tag, chip select and
    // convert select are timed by the host against this clock
    always_ff @(posedge serial_shift_clock) begin
        lrst_s1_r <= srst;
        lrst_r    <= lrst_s1_r;
        ext_s1_r  <= clock_source_select;
        ext_r     <= ext_s1_r;
        tg_s1_r   <= xfer_tgl_r;
        tg_s2_r   <= tg_s1_r;
        tg_s3_r   <= tg_s2_r;
    end

    // External clock mode only: clock edge while deselected, or while selected and converting
    assign arm_cond = ext_r & (cs_n | ~rc_n);
    // Selected with convert select back high: this edge is pulse 1
    assign go_cond  = ~cs_n & rc_n;

    // Next state of the frame sequencer
    always_comb begin
        st_nxt     = st_r;
        idx_nxt    = idx_r;
        tag_nxt    = tag_r;
        sdata_nxt  = sdata_r;
        // Word is stable in the store for a whole conversion
        shadow_nxt = (tg_s2_r ^ tg_s3_r) ? res_word : shadow_r;
        unique case (st_r)
            adsr_pkg::LS_IDLE: begin
                sdata_nxt = adsr_pkg::IDLE_LEVEL;
                if (arm_cond) begin
                    st_nxt = adsr_pkg::LS_ARMED;
                end
            end
            adsr_pkg::LS_ARMED: begin
                if (go_cond) begin
                    // Sync bit out after pulse 1, held until the MSB replaces it at pulse 2
                    sdata_nxt = adsr_pkg::SYNC_LEVEL;
                    idx_nxt   = '0;
                    st_nxt    = adsr_pkg::LS_SHIFT;
                end else begin
                    sdata_nxt = adsr_pkg::IDLE_LEVEL;
                end
            end
            adsr_pkg::LS_SHIFT: begin
                if (cs_n) begin
                    // Deselect aborts the frame and re-arms
                    st_nxt    = adsr_pkg::LS_ARMED;
                    sdata_nxt = adsr_pkg::IDLE_LEVEL;
                end else begin
                    // MSB after pulse 2, LSB after pulse 17
                    sdata_nxt = shadow_r[IDX_LAST - idx_r];
                    if (idx_r == '0) begin
                        tag_nxt = tag_in;
                    end
                    idx_nxt = idx_r + adsr_pkg::IDX_W'(1);
                    if (idx_r == IDX_LAST) begin
                        st_nxt = adsr_pkg::LS_TAIL;
                    end
                end
            end
            adsr_pkg::LS_TAIL: begin
                if (cs_n || !rc_n) begin
                    st_nxt    = adsr_pkg::LS_ARMED;
                    sdata_nxt = adsr_pkg::IDLE_LEVEL;
                end else begin
                    // From pulse 18 on the captured tag is shown
                    sdata_nxt = tag_r;
                end
            end
        endcase
    end

    // Registers of the frame sequencer
    always_ff @(posedge serial_shift_clock) begin
        if (lrst_r) begin
            st_r     <= adsr_pkg::LS_IDLE;
            idx_r    <= '0;
            tag_r    <= 1'b0;
            sdata_r  <= adsr_pkg::IDLE_LEVEL;
            shadow_r <= '0;
        end else begin
            st_r     <= st_nxt;
            idx_r    <= idx_nxt;
            tag_r    <= tag_nxt;
            sdata_r  <= sdata_nxt;
            shadow_r <= shadow_nxt;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    logic shadow_msb, shadow_lsb;  // Helper taps for checks
    assign shadow_msb = shadow_r[W-1];
    assign shadow_lsb = shadow_r[0];

    sequence seq_sync_req;
        st_r == adsr_pkg::LS_ARMED && go_cond;
    endsequence

    sequence seq_first_shift;
        st_r == adsr_pkg::LS_SHIFT && idx_r == '0 && !cs_n;
    endsequence

    AST_BUSY_FALLS: assert property (
        @(posedge clk) disable iff (srst)
        $fell(rc_s2_r) && !cs_s2_r && busy_n_r
        |-> ##[1:BUSY_BOUND] !busy_n_r)
        else $error("Busy did not fall after conversion start");

    AST_RESULT_HELD: assert property (
        @(posedge clk) disable iff (srst)
        !busy_n_r && $past(!busy_n_r) |-> $stable(res_word))
        else $error("Result changed while a conversion ran");

    AST_ARM: assert property (
        @(posedge serial_shift_clock) disable iff (lrst_r)
        st_r == adsr_pkg::LS_IDLE && arm_cond
        |=> st_r == adsr_pkg::LS_ARMED)
        else $error("Sync pulse not armed");

    AST_SYNC_BIT: assert property (
        @(posedge serial_shift_clock) disable iff (lrst_r)
        seq_sync_req |=> sdata_r == adsr_pkg::SYNC_LEVEL
                         && st_r == adsr_pkg::LS_SHIFT)
        else $error("Sync bit not driven after pulse 1");

    AST_MSB: assert property (
        @(posedge serial_shift_clock) disable iff (lrst_r)
        seq_sync_req ##1 seq_first_shift
        |=> sdata_r == $past(shadow_msb))
        else $error("MSB not driven after pulse 2");

    AST_LSB: assert property (
        @(posedge serial_shift_clock) disable iff (lrst_r)
        st_r == adsr_pkg::LS_SHIFT && idx_r == IDX_LAST && !cs_n
        |=> sdata_r == $past(shadow_lsb) && st_r == adsr_pkg::LS_TAIL)
        else $error("LSB not driven after pulse 17");

    // Tag level is latched on pulse 2
    AST_TAG_CAPTURE: assert property (
        @(posedge serial_shift_clock) disable iff (lrst_r)
        seq_first_shift |=> tag_r == $past(tag_in))
        else $error("Tag level not captured at pulse 2");

    // Pulse 2 plus sixteen edges is pulse 18; still in the tail means
    // no abort happened, so the tag seen at pulse 2 must be shown
    AST_TAG_OUT: assert property (
        @(posedge serial_shift_clock) disable iff (lrst_r)
        seq_first_shift ##16 (st_r == adsr_pkg::LS_TAIL && go_cond)
        |=> sdata_r == $past(tag_in, 17))
        else $error("Tag level not shown after pulse 18");

endmodule // adsr_readout

// ---- hdl/adsr_result_store.sv ----
// Result store: holds the last finished conversion word
module adsr_result_store #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_data,
    output logic      [W-1:0] rd_data
);

    logic [W-1:0] word_nxt;  // Next stored word

    // Keep the word unless a new result is written
    always_comb begin
        word_nxt = wr_en ? wr_data : rd_data;
    end

    // Read data come straight from the storage register
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_data <= '0;
        end else begin
            rd_data <= word_nxt;
        end
    end

endmodule // adsr_result_store

// ---- sim/adsr_host_model.sv ----
// Host controller model: free shift clock, framing and word assembly
module adsr_host_model (
    output logic serial_shift_clock,
    output logic cs_n,
    output logic rc_n,
    output logic tag_in,
    input  wire logic sdata_r
);
    timeunit 1ns;
    timeprecision 100ps;

    // ************************************************************
    // Continuous shift clock, 32 ns period, runs between frames
    // ************************************************************
    initial begin
        serial_shift_clock = 1'h0;
        cs_n               = 1'h1;  // Deselected while idle
        rc_n               = 1'h1;  // No conversion request
        tag_in             = 1'h0;
        forever #16 serial_shift_clock = ~serial_shift_clock;
    end

    // ************************************************************
    // One frame; link lines change on falling edges only
    // ************************************************************
    task automatic frame(input logic conv, input logic tagv,
                         output logic sync, output logic [15:0] word,
                         output logic tag);
        @(negedge serial_shift_clock);
        cs_n <= ~conv;
        rc_n <= ~conv;
        @(negedge serial_shift_clock);
        cs_n   <= 1'h0;
        rc_n   <= 1'h1;
        tag_in <= tagv;            // Held over pulse 2
        @(negedge serial_shift_clock);
        sync = sdata_r;
        @(negedge serial_shift_clock);
        tag_in   <= ~tagv;         // Proves tag sampling at pulse 2
        word[15] = sdata_r;
        for (int i = 14; i >= 0; i--) begin
            @(negedge serial_shift_clock);
            word[i] = sdata_r;
        end
        @(negedge serial_shift_clock);
        tag    = sdata_r;
        cs_n   <= 1'h1;
        tag_in <= 1'h0;
    endtask
endmodule // adsr_host_model

// ---- sim/adsr_readout_tb_top.sv ----
// Testbench for the serial result readout block
module adsr_readout_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    // ************************************************************
    // Signals and counters
    // ************************************************************
    logic        clk;                 // System clock
    logic        srst;                // Synchronous reset
    logic        clock_source_select; // External clock mode
    logic [15:0] conv_word;           // Core result
    logic        busy_n_r;            // Busy, active low
    logic        sdata_r;             // Serial data
    logic        sclk, cs_n, rc_n, tag_in;
    logic        sy, tg;
    logic [15:0] wd;
    int          fail_count;
    int          n_tests;
    realtime     t_start;

    // Long conversion keeps the frame in the first half of busy
    adsr_readout #(.W(16), .CONV_CYC(150)) dut (
        .clk(clk), .srst(srst), .serial_shift_clock(sclk),
        .cs_n(cs_n), .rc_n(rc_n), .tag_in(tag_in),
        .clock_source_select(clock_source_select),
        .conv_word(conv_word), .busy_n_r(busy_n_r), .sdata_r(sdata_r));

    adsr_host_model host (.serial_shift_clock(sclk), .cs_n(cs_n),
        .rc_n(rc_n), .tag_in(tag_in), .sdata_r(sdata_r));

    // ************************************************************
    // Clock, checks and closing
    // ************************************************************
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Start-to-busy delay measured on every conversion request
    always @(negedge rc_n) t_start = $realtime;
    always @(negedge busy_n_r) begin
        chk("busy delay ok", 16'h1, 16'(($realtime - t_start) <= 83.0));
    end

    // Bounded wait for the end of a conversion, then link settling
    task automatic wait_idle();
        int k;
        for (k = 0; k < 400 && busy_n_r !== 1'h1; k++) @(posedge clk);
        chk("busy released", 16'h1, 16'(busy_n_r));
        repeat (8) @(posedge sclk);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_no_ext();
        host.frame(1'h0, 1'h1, sy, wd, tg);
        chk("sync internal", 16'h0, 16'(sy));
        chk("word internal", 16'h0000, wd);
        $display("t_no_ext done");
    endtask

    task automatic t_convert(input logic [15:0] nw, input logic tv,
                             input logic [15:0] exp);
        @(posedge clk);
        conv_word <= nw;
        host.frame(1'h1, tv, sy, wd, tg);
        chk("sync", 16'h1, 16'(sy));
        chk("word", exp, wd);
        chk("tag", 16'(tv), 16'(tg));
        chk("busy mid", 16'h0, 16'(busy_n_r));
        wait_idle();
        $display("t_convert done");
    endtask

    task automatic t_cs_arm();
        host.frame(1'h0, 1'h1, sy, wd, tg);
        chk("sync cs", 16'h1, 16'(sy));
        chk("word cs", 16'h3C5A, wd);
        chk("tag cs", 16'h1, 16'(tg));
        chk("no start", 16'h1, 16'(busy_n_r));
        $display("t_cs_arm done");
    endtask

    initial begin
        fail_count          = 0;
        n_tests             = 0;
        t_start             = 0;
        srst                = 1'h1;
        clock_source_select = 1'h0;
        conv_word           = 16'h0000;
        repeat (16) @(posedge clk);
        srst <= 1'h0;
        repeat (4) @(posedge sclk);
        t_no_ext();
        @(posedge clk);
        clock_source_select <= 1'h1;
        repeat (4) @(posedge sclk);
        t_convert(16'hA5C3, 1'h1, 16'h0000);
        t_convert(16'h3C5A, 1'h0, 16'hA5C3);
        t_cs_arm();
        summarize();
    end

    // Watchdog well beyond the expected few microseconds
    initial begin
        #100us;
        fail_count++;
        summarize();
    end
endmodule // adsr_readout_tb_top
